// file: hdl/lbsc_pkg.sv
// Constants, register map and types of the LIN break/synch control block.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
package lbsc_pkg;

  // ---------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          ADDR_W   = 14;
  localparam logic [11:0] IDX_COLL = 12'h105;
  localparam logic [11:0] IDX_MAIN = 12'h106;
  localparam logic [11:0] IDX_STAT = 12'h107;
  localparam logic [11:0] IDX_PER  = 12'h108;
  localparam logic [11:0] IDX_MEAS = 12'h109;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int B_FDIE   = 0;
  localparam int B_BKIE   = 1;
  localparam int B_CLIE   = 2;
  localparam int B_MASK   = 3;
  localparam int B_ARM    = 4;
  localparam int B_UNMSEL = 5;
  localparam int B_MST    = 6;
  localparam int B_LINE   = 7;
  localparam int B_BCE    = 0;
  localparam int COLL_W   = 4;
  localparam int B_FDF    = 0;
  localparam int B_BKF    = 1;
  localparam int B_CLF    = 2;
  localparam int B_CLR0   = 3;
  localparam int B_START  = 16;

  localparam logic [7:0]        MAIN_RST = 8'h00;
  localparam logic [COLL_W-1:0] COLL_RST = 4'h0;
  localparam logic [2:0]        FLAG_RST = 3'h0;

  // Falling edges from start bit to the end of data bit 6 of 55h
  localparam logic [2:0] FIELD_EDGES = 3'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_NS     = 80;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_DETECT = 2'h1,
    ST_FIELD  = 2'h3,
    ST_GEN    = 2'h2
  } lbsc_state_t;

  function automatic logic lbsc_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    return a == {idx, 2'h0};
  endfunction : lbsc_hit

endpackage : lbsc_pkg

// file: hdl/lbsc_top.sv
// LIN break generation/detection, synch field measurement and rx masking.
// Assumes an Avalon-MM master on mclk and the serial port's tx on mclk.
`timescale 1ns/1ps
module lbsc_top
  import lbsc_pkg::*;
#(
  parameter int PERIOD_W = 16
)(
  input  wire logic              mclk,            // System clock
  input  wire logic              reset_n,         // Async reset, active low
  input  wire logic [ADDR_W-1:0] avs_address,     // Byte address
  input  wire logic              avs_read,        // Read request
  input  wire logic              avs_write,       // Write request
  input  wire logic [31:0]       avs_writedata,   // Write data
  input  wire logic [3:0]        avs_byteenable,  // Byte lanes
  output logic      [31:0]       avs_readdata,    // Read data
  output logic                   avs_waitrequest, // Stall
  input  wire logic              rx_pin,          // LIN receive pin
  output logic                   tx_pin,          // LIN transmit pin
  input  wire logic              uart_txd,        // Serial port transmit
  output logic                   uart_rxd,        // Serial port receive
  output logic                   lin_irq          // Interrupt pulse
);

  localparam logic [PERIOD_W-1:0] CNT_ONE = {{(PERIOD_W-1){1'b0}}, 1'b1};
  localparam logic [PERIOD_W-1:0] SETTLE  = PERIOD_W'(SETTLE_CYC);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]          main_r;
  logic [COLL_W-1:0]   coll_r;
  logic [2:0]          flags_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] meas_r;
  logic [PERIOD_W-1:0] cnt_r;
  logic [2:0]          edge_r;
  logic                masked_r;
  lbsc_state_t         state_r;
  logic                rx_s1_r;
  logic                rx_s2_r;
  logic                rx_s3_r;
  logic                wait_r;
  logic [31:0]         rdata_r;
  logic                tx_r;
  logic                urx_r;
  logic                irq_r;

  logic [7:0]          main_nxt;
  logic [2:0]          flags_nxt;
  logic [PERIOD_W-1:0] meas_nxt;
  logic [PERIOD_W-1:0] cnt_nxt;
  logic [2:0]          edge_nxt;
  logic                masked_nxt;
  lbsc_state_t         state_nxt;
  logic                fd_set;
  logic                bk_set;
  logic                cl_set;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire       wr_ok    = avs_write & ~wait_r;
  wire       wr_main  = wr_ok & avs_byteenable[0] & lbsc_hit(avs_address, IDX_MAIN);
  wire       wr_coll  = wr_ok & avs_byteenable[0] & lbsc_hit(avs_address, IDX_COLL);
  wire       wr_stat  = wr_ok & avs_byteenable[0] & lbsc_hit(avs_address, IDX_STAT);
  wire       wr_per   = wr_ok & (&avs_byteenable[1:0]) & lbsc_hit(avs_address, IDX_PER);
  wire       wr_start = wr_ok & avs_byteenable[2] & lbsc_hit(avs_address, IDX_PER)
                        & avs_writedata[B_START];
  wire [7:0] wd8      = avs_writedata[7:0];
  wire [2:0] clr      = wr_stat ? wd8[B_CLR0+2:B_CLR0] : 3'h0;
  wire [2:0] set_ev   = {cl_set, bk_set, fd_set};
  wire [2:0] irq_en   = {main_r[B_CLIE], main_r[B_BKIE], main_r[B_FDIE]};
  // Event that moves a flag from clear to set
  wire [2:0] set_new  = set_ev & ~(flags_r & ~clr);
  wire       line_on  = main_r[B_LINE];
  wire       line_up  = wr_main & wd8[B_LINE] & ~line_on;
  wire       line_dn  = wr_main & ~wd8[B_LINE];
  wire       arm_ev   = wr_main & wd8[B_ARM] & wd8[B_LINE] & ~wd8[B_MST];
  wire       rx_fall  = rx_s3_r & ~rx_s2_r;
  wire       cnt_last = cnt_r == period_r - CNT_ONE;
  wire       gen_on   = state_r == ST_GEN;

  // masked flag in bit 3, arm bit reads zero
  wire [7:0] rd_main  = {main_r[7:5], 1'b0, masked_r, main_r[2:0]};
  wire [7:0] rd_coll  = {{(8-COLL_W){1'b0}}, coll_r};
  wire [31:0] rd_mux  =
    lbsc_hit(avs_address, IDX_MAIN) ? {24'h000000, rd_main} :
    lbsc_hit(avs_address, IDX_COLL) ? {24'h000000, rd_coll} :
    lbsc_hit(avs_address, IDX_STAT) ? {29'h00000000, flags_r} :
    lbsc_hit(avs_address, IDX_PER)  ? (32'(period_r) | (32'(gen_on) << B_START)) :
    lbsc_hit(avs_address, IDX_MEAS) ? 32'(meas_r) : 32'h00000000;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_comb
  begin
    main_nxt         = main_r;
    main_nxt[B_MASK] = 1'b0;
    main_nxt[B_ARM]  = 1'b0;
    if (wr_main)
    begin
      main_nxt = {wd8[7:5], 2'h0, wd8[2:0]};
    end
  end

  assign flags_nxt = (flags_r & ~clr) | set_ev;

  // ---------------------------------------------------------------
  // Break and field sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt  = state_r;
    masked_nxt = masked_r;
    cnt_nxt    = cnt_r;
    edge_nxt   = edge_r;
    meas_nxt   = meas_r;
    fd_set     = 1'b0;
    bk_set     = 1'b0;
    cl_set     = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (wr_start & line_on & main_r[B_MST])
        begin
          state_nxt = ST_GEN;
          cnt_nxt   = '0;
        end
      end
      ST_GEN:
      begin
        cnt_nxt = cnt_r + CNT_ONE;
        // collision: bus high while break drives low
        if (coll_r[B_BCE] & (cnt_r >= SETTLE) & rx_s2_r)
        begin
          cl_set = 1'b1;
        end
        if (cnt_last)
        begin
          bk_set     = 1'b1;
          masked_nxt = 1'b0;
          state_nxt  = ST_IDLE;
        end
      end
      ST_DETECT:
      begin
        // low for the period is a break
        cnt_nxt = rx_s2_r ? '0 : cnt_r + CNT_ONE;
        if (~rx_s2_r & cnt_last)
        begin
          bk_set    = 1'b1;
          state_nxt = ST_FIELD;
          cnt_nxt   = '0;
          edge_nxt  = 3'h0;
          if (~main_r[B_UNMSEL])
          begin
            masked_nxt = 1'b0;
          end
        end
      end
      ST_FIELD:
      begin
        if (edge_r != 3'h0)
        begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
        if (rx_fall)
        begin
          edge_nxt = edge_r + 3'h1;
          if (edge_r == 3'h0)
          begin
            cnt_nxt = '0;
          end
          if (edge_r == FIELD_EDGES - 3'h1)
          begin
            fd_set     = 1'b1;
            meas_nxt   = cnt_r + CNT_ONE;
            masked_nxt = 1'b0;
            state_nxt  = ST_IDLE;
          end
        end
      end
    endcase
    if (arm_ev)
    begin
      state_nxt  = ST_DETECT;
      masked_nxt = 1'b1;
      cnt_nxt    = '0;
    end
    if (line_up & ~arm_ev)
    begin
      state_nxt  = ST_IDLE;
      masked_nxt = 1'b1;
    end
    if (line_dn)
    begin
      state_nxt  = ST_IDLE;
      masked_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_r   <= MAIN_RST;
      coll_r   <= COLL_RST;
      flags_r  <= FLAG_RST;
      period_r <= '0;
      meas_r   <= '0;
      cnt_r    <= '0;
      edge_r   <= 3'h0;
      masked_r <= 1'b0;
      state_r  <= ST_IDLE;
    end
    else
    begin
      main_r   <= main_nxt;
      coll_r   <= wr_coll ? wd8[COLL_W-1:0] : coll_r;
      flags_r  <= flags_nxt;
      period_r <= wr_per ? avs_writedata[PERIOD_W-1:0] : period_r;
      meas_r   <= meas_nxt;
      cnt_r    <= cnt_nxt;
      edge_r   <= edge_nxt;
      masked_r <= masked_nxt;
      state_r  <= state_nxt;
    end
  end

  // pins; low-active OR of break onto serial tx
  // no wake logic here; wake comes on a separate input
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
      tx_r    <= 1'b1;
      urx_r   <= 1'b1;
      irq_r   <= 1'b0;
    end
    else
    begin
      wait_r  <= wait_r ? ~(avs_read | avs_write) : 1'b1;
      rdata_r <= (wait_r & avs_read) ? rd_mux : rdata_r;
      tx_r    <= uart_txd & ~(state_nxt == ST_GEN);
      urx_r   <= rx_s2_r | masked_nxt;
      irq_r   <= |(set_new & irq_en);
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign tx_pin          = tx_r;
  assign uart_rxd        = urx_r;
  assign lin_irq         = irq_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_COLL_EN: assert property (@(posedge mclk) disable iff (!reset_n)
    cl_set |-> coll_r[B_BCE] && gen_on)
    else $error("collision flagged without enable or break");
  AST_COLL_RSV: assert property (@(posedge mclk) disable iff (!reset_n)
    wait_r && avs_read && lbsc_hit(avs_address, IDX_COLL) |=> avs_readdata[31:4] == 28'h0)
    else $error("unused collision bits not zero");
  AST_FD_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
    fd_set && !flags_r[B_FDF] && main_r[B_FDIE] |=> irq_r)
    else $error("field irq missing");
  AST_BK_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
    bk_set && !flags_r[B_BKF] && main_r[B_BKIE] |=> irq_r)
    else $error("break irq missing");
  AST_CL_IRQ: assert property (@(posedge mclk) disable iff (!reset_n)
    cl_set && !flags_r[B_CLF] && main_r[B_CLIE] |=> irq_r)
    else $error("collision irq missing");
  AST_MASK_RD: assert property (@(posedge mclk) disable iff (!reset_n)
    wait_r && avs_read && lbsc_hit(avs_address, IDX_MAIN)
    |=> avs_readdata[B_MASK] == $past(masked_r) && !avs_readdata[B_ARM])
    else $error("main read shows wrong mask or arm");
  AST_ARM_MASK: assert property (@(posedge mclk) disable iff (!reset_n)
    arm_ev |=> masked_r && state_r == ST_DETECT ##1 uart_rxd)
    else $error("arm did not mask rx");
  AST_UNMASK: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == ST_DETECT && bk_set && !main_r[B_UNMSEL] && !wr_main |=> !masked_r)
    else $error("early unmask missing");
  AST_LINE_DN: assert property (@(posedge mclk) disable iff (!reset_n)
    line_dn |=> state_r == ST_IDLE && !masked_r)
    else $error("stop did not idle");
  AST_LINE_UP: assert property (@(posedge mclk) disable iff (!reset_n)
    line_up && !arm_ev |=> masked_r ##1 uart_rxd)
    else $error("start did not block inputs");
  AST_GEN_LOW: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(gen_on) |-> !tx_pin [*2])
    else $error("break not driven low");
  AST_DETECT: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == ST_DETECT && !rx_s2_r && cnt_last && !wr_main
    |=> state_r == ST_FIELD && flags_r[B_BKF])
    else $error("break not detected");
  AST_CLR: assert property (@(posedge mclk) disable iff (!reset_n)
    clr[B_FDF] && !fd_set |=> !flags_r[B_FDF])
    else $error("field flag not cleared");
  AST_IRQ_SRC: assert property (@(posedge mclk) disable iff (!reset_n)
    irq_r |-> $past(set_ev & irq_en) != 3'h0)
    else $error("irq without enabled event");

endmodule : lbsc_top

// file: sim/lbsc_lin_node.sv
// Far LIN node on the single-wire bus, with the line's pull-up.
// Assumes the bench calls its task just after a rising edge of mclk.
`timescale 1ns/1ps
module lbsc_lin_node (
  input  wire logic mclk,   // System clock
  input  wire logic tx_pin, // Device transmit pin
  output logic      rx_pin  // Bus level seen by the device
);
  logic drv_n; // Node pulls the line low when 0
  logic jam;   // Fault: line stuck high
  initial
  begin
    drv_n = 1'b1;
    jam   = 1'b0;
  end
  assign rx_pin = jam | (tx_pin & drv_n);
  // holds a level for a count of cycles
  task automatic hold(input logic v, input int n);
    drv_n <= v;
    repeat (n) @(posedge mclk);
  endtask : hold
endmodule : lbsc_lin_node

// file: sim/tb_lin_break_sync_control.sv
// Self-checking bench of the LIN break and synch control block.
// Assumes lbsc_pkg, lbsc_top and the far node model lbsc_lin_node.
`timescale 1ns/1ps
module tb_lin_break_sync_control;
  import lbsc_pkg::*;
  localparam int P  = 10;
  localparam int BT = 6;
  logic              mclk          = 1'b0;
  logic              reset_n       = 1'b0;
  logic [ADDR_W-1:0] avs_address   = '0;
  logic              avs_read      = 1'b0;
  logic              avs_write     = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic [31:0]       rd;
  logic              avs_waitrequest;
  logic              rx_pin;
  logic              tx_pin;
  logic              uart_txd      = 1'b1;
  logic              uart_rxd;
  logic              lin_irq;
  logic              mon           = 1'b0;
  logic              saw0          = 1'b0;
  logic [31:0]       seed          = 32'hBEBB64BF;
  int                error_cnt     = 0;
  int                compares      = 0;
  int                cyc           = 0;
  int                irqs          = 0;
  int                txlow         = 0;

  always #10 mclk = ~mclk;

  lbsc_top #(.PERIOD_W(16)) u_lbsc_top (
    .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .uart_txd(uart_txd), .uart_rxd(uart_rxd), .lin_irq(lin_irq));
  lbsc_lin_node u_lbsc_lin_node (.mclk(mclk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  // ---------------------------------------------------------------
  // Monitors and timeout
  // ---------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc++;
    if (lin_irq === 1'b1) irqs++;
    if (tx_pin === 1'b0) txlow++;
    if (mon && uart_rxd === 1'b0) saw0 = 1'b1;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Main readback with run bit off: status bit and arm bit read 0
  function automatic logic [31:0] main_exp(input logic [31:0] w);
    return w & 32'h67;
  endfunction : main_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic [11:0] idx, input logic w, input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= {idx, 2'h0};
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do
    begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] w;
    logic [31:0] en;
    logic        c;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    check(tx_pin, 1'b1);
    check(uart_rxd, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      bus((i == 5) ? 12'h1FF : 12'h105 + 12'(i), 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    $display("test reset done");
    repeat (4)
    begin
      w = rnd();
      bus(IDX_COLL, 1'b1, w);
      bus(IDX_COLL, 1'b0, 32'h0);
      check(rd, w & 32'hF);
      w = rnd() & 32'h7F;
      bus(IDX_MAIN, 1'b1, w);
      bus(IDX_MAIN, 1'b0, 32'h0);
      check(rd, main_exp(w));
    end
    bus(IDX_MAIN, 1'b1, 32'h0);
    $display("test registers done");
    u_lbsc_lin_node.hold(1'b0, 5);
    check(uart_rxd, 1'b0);
    bus(IDX_MAIN, 1'b1, 32'hC0);
    @(posedge mclk);
    check(uart_rxd, 1'b1);
    bus(IDX_MAIN, 1'b0, 32'h0);
    check(rd[B_MASK], 1'b1);
    u_lbsc_lin_node.hold(1'b1, 2);
    bus(IDX_MAIN, 1'b1, 32'h0);
    uart_txd <= 1'b0;
    repeat (2) @(posedge mclk);
    check(tx_pin, 1'b0);
    uart_txd <= 1'b1;
    $display("test masking done");
    for (int k = 0; k < 3; k++)
    begin
      c  = (k == 2);
      en = rnd() & 32'h6;
      bus(IDX_STAT, 1'b1, 32'h38);
      bus(IDX_STAT, 1'b0, 32'h0);
      check(rd, 32'h0);
      bus(IDX_COLL, 1'b1, 32'(k != 0));
      bus(IDX_MAIN, 1'b1, 32'hC0 | en);
      bus(IDX_PER, 1'b1, 32'(P));
      irqs  = 0;
      txlow = 0;
      u_lbsc_lin_node.jam <= (k != 1);
      // Start write also rewrites the period lanes
      bus(IDX_PER, 1'b1, 32'h10000 | 32'(P));
      repeat (P + 10) @(posedge mclk);
      u_lbsc_lin_node.jam <= 1'b0;
      bus(IDX_STAT, 1'b0, 32'h0);
      check(rd[2:0], {c, 2'h2});
      if (!c) check(txlow, P);
      check(irqs, int'(en[1]) + int'(en[2] & c));
      bus(IDX_MAIN, 1'b1, 32'h0);
    end
    $display("test master done");
    for (int s = 0; s < 2; s++)
    begin
      en = rnd() & 32'h3;
      bus(IDX_STAT, 1'b1, 32'h38);
      bus(IDX_MAIN, 1'b1, 32'h90 | (32'(s) << 5) | en);
      bus(IDX_MAIN, 1'b0, 32'h0);
      check(rd[B_MASK], 1'b1);
      irqs = 0;
      u_lbsc_lin_node.hold(1'b0, P - 3);
      u_lbsc_lin_node.hold(1'b1, 4);
      bus(IDX_STAT, 1'b0, 32'h0);
      check(rd[2:0], 3'h0);
      u_lbsc_lin_node.hold(1'b0, P + 3);
      u_lbsc_lin_node.hold(1'b1, 4);
      saw0 = 1'b0;
      for (int i = 0; i < 10; i++)
      begin
        mon <= (i < 7);
        u_lbsc_lin_node.hold(i[0], BT);
      end
      repeat (6) @(posedge mclk);
      check(saw0, 1'(s == 0));
      bus(IDX_STAT, 1'b0, 32'h0);
      check(rd[2:0], 3'h3);
      bus(IDX_MEAS, 1'b0, 32'h0);
      check(32'(rd >= 8 * BT - 2 && rd <= 8 * BT + 2), 32'h1);
      check(irqs, int'(en[0]) + int'(en[1]));
      bus(IDX_MAIN, 1'b1, 32'h0);
    end
    $display("test slave done");
    wrap_up();
  end
endmodule : tb_lin_break_sync_control
